/* File: inc/fco_pkg.sv */
// Package of constants and types for the flash clock and option control block
package fco_pkg;
   // ****************************************************************
   // Register map (byte addresses, one aligned word each)
   // ****************************************************************
   localparam logic [7:0] FCO_ADDR_CLKDIV = 8'h00;
   localparam logic [7:0] FCO_ADDR_OPTIONS = 8'h04;
   localparam logic [7:0] FCO_ADDR_PROTECT = 8'h08;
   localparam logic [7:0] FCO_ADDR_KEYCTL = 8'h0C;
   localparam logic [7:0] FCO_ADDR_KEYDATA = 8'h10;
   localparam logic [7:0] FCO_ADDR_CMD = 8'h14;
   localparam logic [7:0] FCO_ADDR_STATUS = 8'h18;
   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int FCO_LOADED_BIT = 7;
   localparam int FCO_PRESCALE_BIT = 6;
   localparam int FCO_RATIO_MSB = 5;
   localparam int FCO_BACKDOOR_BIT = 7;
   localparam int FCO_REDIR_BIT = 6;
   localparam int FCO_LOCK_MSB = 1;
   localparam int FCO_PROT_DIS_BIT = 0;
   localparam int FCO_KEYACC_BIT = 0;
   localparam int FCO_ACCERR_BIT = 0;
   localparam int FCO_KEYBYTES = 8;
   // ****************************************************************
   // Reset values and codes
   // ****************************************************************
   localparam logic [7:0] FCO_CLKDIV_RST = 8'h00;
   localparam logic [1:0] FCO_LOCK_OPEN = 2'h2;
   localparam logic [2:0] FCO_PRESCALE_DIV = 3'h7;
   localparam logic [7:0] FCO_CMD_BLANK = 8'h05;
   localparam logic [31:0] FCO_ZERO_WORD = 32'h0000_0000;
   localparam logic [3:0] FCO_PULSE_RST = 4'h0;
   typedef enum logic [1:0] {
      FCO_IDLE = 2'b00,
      FCO_RUN = 2'b01,
      FCO_DONE = 2'b10
   } fco_seq_t;
endpackage

/* File: src/fco_clk_div.sv */
// Prescaler and programmable divider producing the flash timing pulse
module fco_clk_div
   import fco_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic prescale_by_eight,
   input wire logic [5:0] ratio,
   input wire logic restart,
   output logic fclk_tick
);
   logic [2:0] pre_q, pre_d;
   logic [5:0] cnt_q, cnt_d;
   logic tick_q, tick_d;
   logic pre_tick;

   // Prescale stage then divide by ratio plus one
   always_comb begin
      pre_d = pre_q;
      cnt_d = cnt_q;
      tick_d = 1'b0;
      pre_tick = 1'b1;
      if (prescale_by_eight) begin
         pre_tick = (pre_q == FCO_PRESCALE_DIV);
         pre_d = pre_q + 3'h1;
      end
      if (restart) begin
         pre_d = 3'h0;
         cnt_d = 6'h00;
      end else if (pre_tick) begin
         if (cnt_q >= ratio) begin
            cnt_d = 6'h00;
            tick_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 6'h01;
         end
      end
   end

   // Divider state
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pre_q <= 3'h0;
         cnt_q <= 6'h00;
         tick_q <= 1'b0;
      end else begin
         pre_q <= pre_d;
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign fclk_tick = tick_q;
endmodule

/* File: src/fco_top.sv */
// Flash clock divider, option and security control with an APB slave
//
// Functional notes
// - Byte registers; option and protect copied at reset
// - Loaded flag cleared by reset, set by write
// - Program and erase refused until flag set
// - Prescale bit selects bus clock or clock/8
// - Flash clock is prescaled clock over ratio+1
// - Timing pulse is one bus clock cycle wide, once per flash clock period
// - Working options loaded from stored byte each reset
// - Backdoor enable bit clear blocks key unlocking
// - Matching eight key bytes unlock until reset
// - Debug writes never count toward key unlocking
// - Redirect disable bit selects default vectors
// - Only lock code 1:0 means unsecured
// - Key match or blank flash sets code 1:0
// - Secured blocks unsecured memory accesses
// - Blocked writes ignored, blocked reads return zero
// - Early program or erase sets access error
// - Redirect only with partial protection, never reset vector
//
// Local design decisions: the APB slave port and the register addresses.
module fco_top
   import fco_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] stored_options_byte,
   input wire logic [7:0] stored_protect_byte,
   input wire logic [63:0] stored_unlock_key,
   input wire logic pwrite_from_debug,
   input wire logic flash_blank_ok,
   input wire logic mem_req,
   input wire logic mem_write,
   input wire logic mem_src_secure,
   input wire logic [7:0] mem_rdata_raw,
   output logic mem_allow,
   output logic [7:0] mem_rdata,
   output logic secured,
   output logic redirect_active,
   output logic fclk_pulse,
   output logic op_busy
);
   // ****************************************************************
   // State
   // ****************************************************************
   logic [7:0] flash_clock_ratio_reg_q, flash_clock_ratio_reg_d;
   logic [7:0] working_options_reg_q, working_options_reg_d;
   logic [7:0] working_protect_reg_q, working_protect_reg_d;
   logic strap_done_q, strap_done_d;
   logic keyacc_q, keyacc_d;
   logic [3:0] key_idx_q, key_idx_d;
   logic key_ok_q, key_ok_d;
   logic access_error_flag_q, access_error_flag_d;
   logic [7:0] cmd_q, cmd_d;
   fco_seq_t seq_q, seq_d;
   logic [3:0] pulses_q, pulses_d;
   logic [31:0] prdata_q, prdata_d;
   logic mem_allow_q, mem_allow_d;
   logic [7:0] mem_rdata_q, mem_rdata_d;
   logic secured_q, secured_d;
   logic redir_q, redir_d;
   logic tick;
   logic wr_en, rd_en, restart;
   logic [7:0] key_byte [FCO_KEYBYTES];
   logic unsecured_now, prot_partial;

   // ****************************************************************
   // Key byte split
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < FCO_KEYBYTES; gi++) begin : g_key
         assign key_byte[gi] = stored_unlock_key[8*gi +: 8];
      end
   endgenerate

   // APB strobes, zero wait state
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign restart = wr_en && (paddr == FCO_ADDR_CLKDIV) &&
                    (pwdata[FCO_PRESCALE_BIT:0] != flash_clock_ratio_reg_q[FCO_PRESCALE_BIT:0]);
   assign unsecured_now = (working_options_reg_q[FCO_LOCK_MSB:0] == FCO_LOCK_OPEN);
   assign prot_partial = !working_protect_reg_q[FCO_PROT_DIS_BIT] &&
                         (working_protect_reg_q[7:1] != 7'h00);

   // ****************************************************************
   // Flash clock divider
   // ****************************************************************
   fco_clk_div u_div (
      .clk(clk),
      .rst_b(rst_b),
      .prescale_by_eight(flash_clock_ratio_reg_q[FCO_PRESCALE_BIT]),
      .ratio(flash_clock_ratio_reg_q[FCO_RATIO_MSB:0]),
      .restart(restart),
      .fclk_tick(tick)
   );

   // Register file, key compare and command sequencing
   always_comb begin
      flash_clock_ratio_reg_d = flash_clock_ratio_reg_q;
      working_options_reg_d = working_options_reg_q;
      working_protect_reg_d = working_protect_reg_q;
      strap_done_d = 1'b1;
      keyacc_d = keyacc_q;
      key_idx_d = key_idx_q;
      key_ok_d = key_ok_q;
      access_error_flag_d = access_error_flag_q;
      cmd_d = cmd_q;
      seq_d = seq_q;
      pulses_d = pulses_q;
      // Capture nonvolatile bytes once after reset release
      if (!strap_done_q) begin
         working_options_reg_d = stored_options_byte;
         working_protect_reg_d = stored_protect_byte;
      end
      // Sequencer counts whole flash clock pulses
      case (seq_q)
         FCO_IDLE: begin
         end
         FCO_RUN: begin
            if (tick) begin
               pulses_d = pulses_q - 4'h1;
               if (pulses_q == 4'h1) begin
                  seq_d = FCO_DONE;
               end
            end
         end
         FCO_DONE: begin
            if ((cmd_q == FCO_CMD_BLANK) && flash_blank_ok) begin
               working_options_reg_d[FCO_LOCK_MSB:0] = FCO_LOCK_OPEN;
            end
            seq_d = FCO_IDLE;
         end
         default: seq_d = FCO_IDLE;
      endcase
      if (wr_en) begin
         case (paddr)
            FCO_ADDR_CLKDIV: begin
               flash_clock_ratio_reg_d = {1'b1, pwdata[FCO_PRESCALE_BIT:0]};
            end
            FCO_ADDR_PROTECT: begin
               if (pwrite_from_debug) begin
                  working_protect_reg_d = pwdata[7:0];
               end
            end
            FCO_ADDR_KEYCTL: begin
               if (!pwrite_from_debug) begin
                  keyacc_d = pwdata[FCO_KEYACC_BIT];
                  if (pwdata[FCO_KEYACC_BIT]) begin
                     key_idx_d = 4'h0;
                     key_ok_d = 1'b1;
                  end else if (keyacc_q && key_ok_q && (key_idx_q == 4'h8) &&
                               working_options_reg_q[FCO_BACKDOOR_BIT]) begin
                     working_options_reg_d[FCO_LOCK_MSB:0] = FCO_LOCK_OPEN;
                  end
               end
            end
            FCO_ADDR_KEYDATA: begin
               if (keyacc_q && !pwrite_from_debug && !unsecured_now &&
                   (key_idx_q < 4'h8)) begin
                  if (pwdata[7:0] != key_byte[key_idx_q[2:0]]) begin
                     key_ok_d = 1'b0;
                  end
                  key_idx_d = key_idx_q + 4'h1;
               end
            end
            FCO_ADDR_CMD: begin
               if (!flash_clock_ratio_reg_q[FCO_LOADED_BIT] || (seq_q != FCO_IDLE)) begin
                  access_error_flag_d = 1'b1;
               end else begin
                  cmd_d = pwdata[7:0];
                  pulses_d = pwdata[11:8] | 4'h1;
                  seq_d = FCO_RUN;
               end
            end
            FCO_ADDR_STATUS: begin
               if (pwdata[FCO_ACCERR_BIT]) begin
                  access_error_flag_d = 1'b0;
               end
            end
            default: begin
            end
         endcase
         // A command refused for a clear loaded flag also sets the access error here
         if ((paddr == FCO_ADDR_CMD) && !flash_clock_ratio_reg_q[FCO_LOADED_BIT]) begin
            access_error_flag_d = 1'b1;
         end
      end
   end

   // Registers of the control state
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flash_clock_ratio_reg_q <= FCO_CLKDIV_RST;
         working_options_reg_q <= 8'h00;
         working_protect_reg_q <= 8'h00;
         strap_done_q <= 1'b0;
         keyacc_q <= 1'b0;
         key_idx_q <= 4'h0;
         key_ok_q <= 1'b0;
         access_error_flag_q <= 1'b0;
         cmd_q <= 8'h00;
         seq_q <= FCO_IDLE;
         pulses_q <= FCO_PULSE_RST;
      end else begin
         flash_clock_ratio_reg_q <= flash_clock_ratio_reg_d;
         working_options_reg_q <= working_options_reg_d;
         working_protect_reg_q <= working_protect_reg_d;
         strap_done_q <= strap_done_d;
         keyacc_q <= keyacc_d;
         key_idx_q <= key_idx_d;
         key_ok_q <= key_ok_d;
         access_error_flag_q <= access_error_flag_d;
         cmd_q <= cmd_d;
         seq_q <= seq_d;
         pulses_q <= pulses_d;
      end
   end

   // ****************************************************************
   // Read mux and registered outputs
   // ****************************************************************
   always_comb begin
      prdata_d = FCO_ZERO_WORD;
      if (rd_en) begin
         case (paddr)
            FCO_ADDR_CLKDIV: prdata_d[7:0] = flash_clock_ratio_reg_q;
            FCO_ADDR_OPTIONS: prdata_d[7:0] = working_options_reg_q;
            FCO_ADDR_PROTECT: prdata_d[7:0] = working_protect_reg_q;
            FCO_ADDR_KEYCTL: prdata_d[FCO_KEYACC_BIT] = keyacc_q;
            FCO_ADDR_CMD: prdata_d[7:0] = cmd_q;
            FCO_ADDR_STATUS: prdata_d[2:0] = {seq_q != FCO_IDLE, 1'b0, access_error_flag_q};
            default: prdata_d = FCO_ZERO_WORD;
         endcase
      end
      // Memory gate: unsecured sources see nothing while secured
      mem_allow_d = mem_req && (unsecured_now || mem_src_secure);
      mem_rdata_d = 8'h00;
      if (mem_req && !mem_write && mem_allow_d) begin
         mem_rdata_d = mem_rdata_raw;
      end
      secured_d = !unsecured_now;
      redir_d = !working_options_reg_q[FCO_REDIR_BIT] && prot_partial;
   end

   // Output flip-flops
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata_q <= FCO_ZERO_WORD;
         mem_allow_q <= 1'b0;
         mem_rdata_q <= 8'h00;
         secured_q <= 1'b1;
         redir_q <= 1'b0;
      end else begin
         prdata_q <= prdata_d;
         mem_allow_q <= mem_allow_d;
         mem_rdata_q <= mem_rdata_d;
         secured_q <= secured_d;
         redir_q <= redir_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign mem_allow = mem_allow_q;
   assign mem_rdata = mem_rdata_q;
   assign secured = secured_q;
   assign redirect_active = redir_q;
   assign fclk_pulse = tick;
   assign op_busy = (seq_q != FCO_IDLE);
endmodule

/* File: testbench/fco_top_chk.sv */
// Checker of port relations of the flash clock and option control block
module fco_top_chk (
   input logic clk,
   input logic rst_b,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [31:0] prdata,
   input logic pready,
   input logic pslverr,
   input logic mem_req,
   input logic mem_write,
   input logic mem_src_secure,
   input logic [7:0] mem_rdata_raw,
   input logic mem_allow,
   input logic [7:0] mem_rdata,
   input logic secured
);
   // ****************************************************************
   // Bus and memory gate relations
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_apb_ready; psel |-> pready && !pslverr; endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("slave stalled");
   property p_rd_idle; prdata != 32'h0 |-> $past(psel) && $past(penable) && !$past(pwrite);
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read");
   property p_src_ok; mem_req && mem_src_secure |=> mem_allow; endproperty
   a_src_ok: assert property (p_src_ok) else $error("secure source refused");
   property p_unsec_ok; mem_req && !secured |=> mem_allow; endproperty
   a_unsec_ok: assert property (p_unsec_ok) else $error("unsecured access refused");
   property p_sec_block; mem_req && !mem_src_secure ##1 secured |-> !mem_allow; endproperty
   a_sec_block: assert property (p_sec_block) else $error("secured access allowed");
   property p_no_req; !mem_req |=> !mem_allow; endproperty
   a_no_req: assert property (p_no_req) else $error("grant without request");
   property p_blk_zero; !mem_allow |-> mem_rdata == 8'h00; endproperty
   a_blk_zero: assert property (p_blk_zero) else $error("blocked data not zero");
   property p_rd_pass; mem_req && !mem_write ##1 mem_allow |-> mem_rdata == $past(mem_rdata_raw);
   endproperty
   a_rd_pass: assert property (p_rd_pass) else $error("allowed read data wrong");
   property p_stay_open; !secured |=> !secured; endproperty
   a_stay_open: assert property (p_stay_open) else $error("security relocked");
endmodule

bind fco_top fco_top_chk u_chk (.clk, .rst_b, .psel, .penable, .pwrite, .prdata, .pready,
   .pslverr, .mem_req, .mem_write, .mem_src_secure, .mem_rdata_raw, .mem_allow, .mem_rdata,
   .secured);

/* File: testbench/test_fco_top.sv */
// Self-checking testbench of the flash clock and option control block
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
   $display("[FAIL] %0t mismatch got %0h exp %0h", $time, (g), (e)); end end
module test_fco_top
   import fco_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [63:0] KEY = 64'h0123_4567_89AB_CDEF;
   logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, stored_options_byte = 8'h00, stored_protect_byte = 8'h00;
   logic [7:0] mem_rdata_raw = 8'hA5, mem_rdata;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [63:0] stored_unlock_key = KEY;
   logic pwrite_from_debug = 1'b0, flash_blank_ok = 1'b0, mem_req = 1'b0, mem_write = 1'b0;
   logic mem_src_secure = 1'b0, pready, pslverr, mem_allow, secured, redirect_active;
   logic fclk_pulse, op_busy;
   int errors = 0;
   int check_count = 0;
   // ****************************************************************
   // Clock, design and shared tasks
   // ****************************************************************
   initial forever #5 clk = ~clk;
   fco_top uut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .stored_options_byte, .stored_protect_byte, .stored_unlock_key,
      .pwrite_from_debug, .flash_blank_ok, .mem_req, .mem_write, .mem_src_secure,
      .mem_rdata_raw, .mem_allow, .mem_rdata, .secured, .redirect_active, .fclk_pulse, .op_busy);
   task automatic test_done();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // One APB transfer; read data is taken in the cycle after the access edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         errors++;
         test_done();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
      rd = prdata;
   endtask
   task automatic do_reset(input logic [7:0] o, input logic [7:0] p);
      rst_b <= 1'b0;
      stored_options_byte <= o;
      stored_protect_byte <= p;
      tick(5);
      rst_b <= 1'b1;
      tick(2);
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic mem_chk(input logic s, input logic w, input logic exp);
      mem_req <= 1'b1;
      mem_write <= w;
      mem_src_secure <= s;
      tick(1);
      mem_req <= 1'b0;
      `CHK(mem_allow, exp)
      `CHK(mem_rdata, (exp && !w) ? 8'hA5 : 8'h00)
      tick(1);
   endtask
   task automatic period(input logic [7:0] v, input int exp);
      int n;
      apb(1'b1, FCO_ADDR_CLKDIV, {24'h0, v});
      apb(1'b0, FCO_ADDR_CLKDIV, 32'h0);
      `CHK(rd[7:0], v | 8'h80)
      n = 0;
      while (fclk_pulse !== 1'b1 && n < 600) begin
         tick(1);
         n++;
      end
      if (n >= 600) begin
         errors++;
         test_done();
      end
      n = 0;
      do begin
         tick(1);
         n++;
      end while (fclk_pulse !== 1'b1 && n < 600);
      `CHK(n, exp)
   endtask
   task automatic key_seq(input logic d);
      pwrite_from_debug <= d;
      apb(1'b1, FCO_ADDR_KEYCTL, 32'h1);
      for (int i = 0; i < FCO_KEYBYTES; i++) begin
         apb(1'b1, FCO_ADDR_KEYDATA, {24'h0, KEY[8*i +: 8]});
      end
      apb(1'b1, FCO_ADDR_KEYCTL, 32'h0);
      pwrite_from_debug <= 1'b0;
      tick(5);
   endtask
   task automatic cmd_run(input logic exp);
      logic seen;
      seen = 1'b0;
      apb(1'b1, FCO_ADDR_CMD, {20'h0, 4'h1, FCO_CMD_BLANK});
      repeat (60) begin
         tick(1);
         if (op_busy === 1'b1) seen = 1'b1;
      end
      `CHK(seen, exp)
      `CHK(op_busy, 1'b0)
   endtask
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      tick(1);
      do_reset(8'h83, 8'hDE);
      apb(1'b0, FCO_ADDR_CLKDIV, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b1, FCO_ADDR_OPTIONS, 32'hFF);
      apb(1'b0, FCO_ADDR_OPTIONS, 32'h0);
      `CHK(rd, 32'h83)
      `CHK(secured, 1'b1)
      `CHK(redirect_active, 1'b1)
      apb(1'b1, 8'hFC, 32'hFF);
      apb(1'b0, 8'hFC, 32'h0);
      `CHK(rd, 32'h0)
      mem_chk(1'b0, 1'b0, 1'b0);
      mem_chk(1'b0, 1'b1, 1'b0);
      mem_chk(1'b1, 1'b0, 1'b1);
      cmd_run(1'b0);
      apb(1'b0, FCO_ADDR_STATUS, 32'h0);
      `CHK(rd[FCO_ACCERR_BIT], 1'b1)
      apb(1'b1, FCO_ADDR_STATUS, 32'h1);
      apb(1'b0, FCO_ADDR_STATUS, 32'h0);
      `CHK(rd[FCO_ACCERR_BIT], 1'b0)
      period(8'h00, 1);
      period(8'h03, 4);
      period(8'h42, 24);
      period(8'h7F, 512);
      key_seq(1'b1);
      `CHK(secured, 1'b1)
      key_seq(1'b0);
      `CHK(secured, 1'b0)
      apb(1'b0, FCO_ADDR_OPTIONS, 32'h0);
      `CHK(rd, 32'h82)
      mem_chk(1'b0, 1'b0, 1'b1);
      pwrite_from_debug <= 1'b1;
      apb(1'b1, FCO_ADDR_PROTECT, 32'hFF);
      pwrite_from_debug <= 1'b0;
      tick(2);
      `CHK(redirect_active, 1'b0)
      do_reset(8'h43, 8'hDE);
      apb(1'b0, FCO_ADDR_OPTIONS, 32'h0);
      `CHK(rd, 32'h43)
      `CHK(redirect_active, 1'b0)
      `CHK(secured, 1'b1)
      period(8'h03, 4);
      key_seq(1'b0);
      `CHK(secured, 1'b1)
      flash_blank_ok <= 1'b1;
      cmd_run(1'b1);
      tick(3);
      `CHK(secured, 1'b0)
      test_done();
   end
endmodule
